// *** verilog/eid_pkg.sv ***
package eid_pkg;
  localparam int          EID_DW              = 32;
  localparam int          EID_AW              = 32;
  localparam int          EID_NIN             = 9;
  localparam int          EID_NDET            = 12;
  localparam int          EID_IN_LINES        = 8;
  localparam logic [31:0] EID_OFF_CFG0        = 32'h40002420;
  localparam logic [31:0] EID_OFF_CFG1        = 32'h40002424;
  localparam logic [31:0] EID_OFF_CFG2        = 32'h40002428;
  localparam logic [31:0] EID_OFF_CLR         = 32'h40002430;
  localparam logic [31:0] EID_OFF_NMI_CLR     = 32'h40002434;
  localparam logic [31:0] EID_OFF_WAKE        = 32'h40002438;
  localparam logic [31:0] EID_OFF_STAT        = 32'h40002450;
  localparam logic [31:0] EID_OFF_MASK        = 32'h40002454;
  localparam logic [15:0] EID_CFG_RST         = 16'h0000;
  localparam logic [15:0] EID_MASK_RST        = 16'h0000;
  localparam int          EID_EN_VBUS         = 15;
  localparam int          EID_MODE_VBUS_LO    = 12;
  localparam int          EID_EN_DM           = 11;
  localparam int          EID_MODE_DM_LO      = 8;
  localparam int          EID_EN_DP           = 7;
  localparam int          EID_MODE_DP_LO      = 4;
  localparam int          EID_EN_IN8          = 3;
  localparam int          EID_MODE_IN8_LO     = 0;
  localparam int          EID_CLR_DP          = 9;
  localparam int          EID_CLR_DM          = 10;
  localparam int          EID_CLR_VBUS        = 11;
  localparam int          EID_NMI_BIT         = 12;
  localparam int          EID_WAKE_DP         = 0;
  localparam int          EID_WAKE_DM         = 1;
  localparam int          EID_WAKE_VBUS       = 2;

  typedef enum logic [2:0] {
    EID_TRIG_RISE   = 3'h0,
    EID_TRIG_FALL   = 3'h1,
    EID_TRIG_BOTH   = 3'h2,
    EID_TRIG_HIGH   = 3'h3,
    EID_TRIG_LOW    = 3'h4,
    EID_TRIG_FALL_A = 3'h5,
    EID_TRIG_BOTH_A = 3'h6,
    EID_TRIG_HIGH_A = 3'h7
  } eid_trig_t;

  typedef struct packed {
    logic        on;
    eid_trig_t   trig;
  } eid_det_cfg_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [EID_AW-1:0] paddr;
    logic [EID_DW-1:0] pwdata;
  } eid_apb_req_t;
endpackage

// *** verilog/eid_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module eid_sync
  import eid_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk_in, // System clock.
  input  wire logic             nrst_in,    // Synchronous reset, low.
  input  wire logic [WIDTH-1:0] async_in,   // Asynchronous pins.
  output logic      [WIDTH-1:0] sync_out    // Synchronised levels.
);
  logic [WIDTH-1:0] stage1;

  // Only the second stage reads the first one.
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // eid_sync
`default_nettype wire

// *** verilog/eid_detector.sv ***
`timescale 1ns/100ps
`default_nettype none
module eid_detector
  import eid_pkg::*;
(
  input  wire logic         sys_clk_in, // System clock.
  input  wire logic         nrst_in,    // Synchronous reset, low.
  input  wire eid_det_cfg_t cfg_in,     // Enable and trigger mode.
  input  wire logic         level_in,   // Synchronised input level.
  output logic              event_out   // One event this cycle.
);
  logic prev;
  logic rise;
  logic fall;

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      prev <= 1'b0;
    end else begin
      prev <= level_in;
    end
  end

  assign rise = level_in & ~prev;
  assign fall = ~level_in & prev;

  // Level modes fire every cycle, so a flag stays set through a clear.
  always_comb begin
    event_out = 1'b0;
    if (cfg_in.on) begin
      case (cfg_in.trig)
        EID_TRIG_RISE:   event_out = rise;
        EID_TRIG_FALL,
        EID_TRIG_FALL_A: event_out = fall;
        EID_TRIG_BOTH,
        EID_TRIG_BOTH_A: event_out = rise | fall;
        EID_TRIG_HIGH,
        EID_TRIG_HIGH_A: event_out = level_in;
        EID_TRIG_LOW:    event_out = ~level_in;
        default:         event_out = 1'b0;
      endcase
    end
  end
endmodule // eid_detector
`default_nettype wire

// *** verilog/eid_top.sv ***
// How it works
// - Config register for USB lines and input 8 resets to zero.
// - Bit 15 enables the VBUS detector.
// - Bits 14:12 pick VBUS trigger; codes 5,6,7 alias 1,2,3.
// - Bit 11 enables the D- detector.
// - Bits 10:8 pick D- trigger with the shared encoding.
// - Bit 7 enables the D+ detector.
// - Bits 6:4 pick D+ trigger with the shared encoding.
// - Bit 3 enables detection on input 8.
// - Bits 2:0 pick input 8 trigger with the shared encoding.
// - Writing one to clear bit n clears flag of input n, 0..8.
// - Clear bits 9, 10, 11 clear D+, D- and VBUS flags.
// - Clear bits return to zero by themselves.
// - Non-maskable clear bit 0 clears the pending NMI flag, self-clears.
// - Inputs 0..7 use two companion config registers, same layout.
// - USB detectors set wake status bits, cleared via clear register.
`timescale 1ns/100ps
`default_nettype none
module eid_top
  import eid_pkg::*;
(
  input  wire logic              sys_clk_in,  // System clock, 10 MHz.
  input  wire logic              nrst_in,     // Synchronous reset, low.
  input  wire logic              psel_in,     // APB select.
  input  wire logic              penable_in,  // APB enable.
  input  wire logic              pwrite_in,   // APB write.
  input  wire logic [EID_AW-1:0] paddr_in,    // APB byte address.
  input  wire logic [EID_DW-1:0] pwdata_in,   // APB write data.
  output logic      [EID_DW-1:0] prdata_out,  // APB read data.
  output logic                   pready_out,  // APB ready.
  output logic                   pslverr_out, // APB error.
  input  wire logic [EID_IN_LINES:0] ext_in,  // External inputs 0..8.
  input  wire logic              vbus_in,     // USB VBUS line.
  input  wire logic              dminus_in,   // USB D- line.
  input  wire logic              dplus_in,    // USB D+ line.
  input  wire logic              nmi_in,      // NMI request pulse/level.
  output logic      [EID_NDET-1:0] flag_out,  // Latched event flags.
  output logic                   nmi_out,     // Pending NMI flag.
  output logic                   irq_out      // Masked summary interrupt.
);
  eid_apb_req_t      req;
  logic              wr_en;
  logic              rd_en;
  logic              hit;
  logic [15:0]       cfg [3];
  logic [15:0]       clr_pulse;
  logic              nmi_clr_pulse;
  logic [15:0]       stat;
  logic [15:0]       mask;
  logic [15:0]       stat_set;
  logic [EID_NDET-1:0] det_ev;
  logic [EID_NDET-1:0] raw;
  logic [EID_NDET-1:0] lvl;
  logic              nmi_sync;
  logic              nmi_prev;
  logic [2:0]        wake;
  logic [EID_DW-1:0] next_prdata;
  eid_det_cfg_t      dcfg [EID_NDET];

  assign req = '{psel: psel_in, penable: penable_in, pwrite: pwrite_in,
                 paddr: paddr_in, pwdata: pwdata_in};
  assign wr_en = req.psel & req.penable & req.pwrite;
  assign rd_en = req.psel & ~req.penable & ~req.pwrite;

  // Zero wait states keep the slave trivial; no stall is ever needed.
  assign pready_out = 1'b1;

  always_comb begin
    hit = 1'b1;
    case (req.paddr)
      EID_OFF_CFG0, EID_OFF_CFG1, EID_OFF_CFG2, EID_OFF_CLR,
      EID_OFF_NMI_CLR, EID_OFF_WAKE, EID_OFF_STAT, EID_OFF_MASK: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  assign pslverr_out = req.psel & req.penable & ~hit;

  // Config registers; CFG0/CFG1 hold inputs 0..7, CFG2 the USB lines and 8.
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      cfg[0] <= EID_CFG_RST;
      cfg[1] <= EID_CFG_RST;
      cfg[2] <= EID_CFG_RST;
    end else if (wr_en) begin
      if (req.paddr == EID_OFF_CFG0) cfg[0] <= req.pwdata[15:0];
      if (req.paddr == EID_OFF_CFG1) cfg[1] <= req.pwdata[15:0];
      if (req.paddr == EID_OFF_CFG2) cfg[2] <= req.pwdata[15:0];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      mask <= EID_MASK_RST;
    end else if (wr_en && req.paddr == EID_OFF_MASK) begin
      mask <= req.pwdata[15:0];
    end
  end

  // Clear strobes live one cycle and then drop by themselves.
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      clr_pulse     <= 16'h0000;
      nmi_clr_pulse <= 1'b0;
    end else begin
      clr_pulse     <= (wr_en && req.paddr == EID_OFF_CLR) ?
                       req.pwdata[15:0] : 16'h0000;
      nmi_clr_pulse <= wr_en && req.paddr == EID_OFF_NMI_CLR &&
                       req.pwdata[0];
    end
  end

  // Detector layout: 0..8 inputs, 9 D+, 10 D-, 11 VBUS.
  assign raw = {vbus_in, dminus_in, dplus_in, ext_in};

  eid_sync #(.WIDTH(EID_NDET + 1)) u_sync (
    .sys_clk_in (sys_clk_in),
    .nrst_in    (nrst_in),
    .async_in   ({nmi_in, raw}),
    .sync_out   ({nmi_sync, lvl})
  );

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      dcfg[i] = eid_det_cfg_t'(cfg[i / 4][(i % 4) * 4 +: 4]);
    end
    dcfg[8]  = eid_det_cfg_t'(cfg[2][EID_MODE_IN8_LO +: 4]);
    dcfg[9]  = eid_det_cfg_t'(cfg[2][EID_MODE_DP_LO +: 4]);
    dcfg[10] = eid_det_cfg_t'(cfg[2][EID_MODE_DM_LO +: 4]);
    dcfg[11] = eid_det_cfg_t'(cfg[2][EID_MODE_VBUS_LO +: 4]);
  end

  for (genvar g = 0; g < EID_NDET; g++) begin : g_det
    eid_detector u_det (
      .sys_clk_in (sys_clk_in),
      .nrst_in    (nrst_in),
      .cfg_in     (dcfg[g]),
      .level_in   (lvl[g]),
      .event_out  (det_ev[g])
    );

    // A new event in the same cycle as a clear keeps the flag set.
    always_ff @(posedge sys_clk_in) begin
      if (!nrst_in) begin
        flag_out[g] <= 1'b0;
      end else if (det_ev[g]) begin
        flag_out[g] <= 1'b1;
      end else if (clr_pulse[g]) begin
        flag_out[g] <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      nmi_prev <= 1'b0;
      nmi_out  <= 1'b0;
    end else begin
      nmi_prev <= nmi_sync;
      if (nmi_sync && !nmi_prev) begin
        nmi_out <= 1'b1;
      end else if (nmi_clr_pulse) begin
        nmi_out <= 1'b0;
      end
    end
  end

  // Wake status mirrors the USB flags and shares their clear.
  assign wake = {flag_out[EID_CLR_VBUS], flag_out[EID_CLR_DM],
                 flag_out[EID_CLR_DP]};

  assign stat_set = {3'h0, (nmi_sync & ~nmi_prev), det_ev};

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      stat <= 16'h0000;
    end else begin
      for (int i = 0; i < 16; i++) begin
        if (stat_set[i]) begin
          stat[i] <= 1'b1;
        end else if (wr_en && req.paddr == EID_OFF_STAT && req.pwdata[i]) begin
          stat[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(stat & mask);
    end
  end

  always_comb begin
    next_prdata = '0;
    case (req.paddr)
      EID_OFF_CFG0:   next_prdata[15:0] = cfg[0];
      EID_OFF_CFG1:   next_prdata[15:0] = cfg[1];
      EID_OFF_CFG2:   next_prdata[15:0] = cfg[2];
      EID_OFF_CLR:    next_prdata[15:0] = clr_pulse;
      EID_OFF_NMI_CLR: next_prdata[0]   = nmi_clr_pulse;
      EID_OFF_WAKE:   next_prdata[2:0]  = wake;
      EID_OFF_STAT:   next_prdata[15:0] = stat;
      EID_OFF_MASK:   next_prdata[15:0] = mask;
      default:        next_prdata       = '0;
    endcase
  end

  // Read data is captured in setup so it is registered at the access.
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      prdata_out <= '0;
    end else if (rd_en) begin
      prdata_out <= next_prdata;
    end
  end

  a_cfg_reset_zero: assert property (@(posedge sys_clk_in)
    !nrst_in |=> cfg[2] == 16'h0000)
    else $error("config not zero after reset");

  a_vbus_gate: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    !cfg[2][EID_EN_VBUS] |-> !det_ev[EID_CLR_VBUS])
    else $error("vbus event while disabled");

  a_vbus_high: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    cfg[2][15:12] == 4'hf && lvl[11] |=> flag_out[11])
    else $error("vbus high alias missed");

  a_dm_gate: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    !cfg[2][EID_EN_DM] |-> !det_ev[EID_CLR_DM])
    else $error("d- event while disabled");

  a_dm_low: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    cfg[2][11:8] == 4'hc && !lvl[10] |=> flag_out[10])
    else $error("d- low level missed");

  a_dp_gate: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    !cfg[2][EID_EN_DP] |-> !det_ev[EID_CLR_DP])
    else $error("d+ event while disabled");

  a_dp_fall_alias: assert property (@(posedge sys_clk_in)
    disable iff (!nrst_in)
    cfg[2][7:4] == 4'hd && $fell(lvl[9]) |-> det_ev[9])
    else $error("d+ falling alias missed");

  a_in8_gate: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    !cfg[2][EID_EN_IN8] |-> !det_ev[8])
    else $error("input 8 event while disabled");

  a_in8_rise: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    cfg[2][3:0] == 4'h8 && $rose(lvl[8]) |-> det_ev[8] ##1 flag_out[8])
    else $error("input 8 rising edge missed");

  a_clear_flag: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    clr_pulse[0] && !det_ev[0] |=> !flag_out[0])
    else $error("input 0 flag not cleared");

  a_clear_usb: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    clr_pulse[EID_CLR_VBUS] && !det_ev[11] |=> !flag_out[11])
    else $error("vbus flag not cleared");

  a_clear_self: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    !(wr_en && req.paddr == EID_OFF_CLR) |=> clr_pulse == 16'h0000)
    else $error("clear bits did not self-clear");

  a_nmi_clear: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    nmi_clr_pulse && !(nmi_sync && !nmi_prev) |=> !nmi_out ##0
    !nmi_clr_pulse || $past(wr_en))
    else $error("nmi flag not cleared");

  a_wake_mirror: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    wake[2] == flag_out[11] && wake[0] == flag_out[9])
    else $error("wake status mismatch");

  a_level_refire: assert property (@(posedge sys_clk_in)
    disable iff (!nrst_in)
    cfg[2][3:0] == 4'hb && lvl[8] && clr_pulse[8] |=> flag_out[8])
    else $error("level flag lost on clear");

  a_sync_delay: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    $rose(lvl[0]) |-> $past(raw[0], 2))
    else $error("input not two-stage synchronised");
endmodule // eid_top
`default_nettype wire

// *** sim/eid_pins.sv ***
`timescale 1ns/100ps
`default_nettype none
module eid_pins
  import eid_pkg::*;
(
  input  wire logic                  sys_clk_in, // System clock.
  input  wire logic [12:0]           req_in,     // Wanted pin levels.
  output logic      [EID_IN_LINES:0] ext_out,    // External inputs 0..8.
  output logic                       vbus_out,   // VBUS line.
  output logic                       dminus_out, // D- line.
  output logic                       dplus_out,  // D+ line.
  output logic                       nmi_out     // Non-maskable source.
);
  // The pins follow the request one clock later; the block must still
  // synchronise them, since real pins owe the clock nothing.
  always_ff @(posedge sys_clk_in) begin
    ext_out    <= req_in[8:0];
    dplus_out  <= req_in[9];
    dminus_out <= req_in[10];
    vbus_out   <= req_in[11];
    nmi_out    <= req_in[12];
  end
endmodule // eid_pins
`default_nettype wire

// *** sim/eid_top_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module eid_top_tb;
  import eid_pkg::*;
  logic              sys_clk_in;
  logic              nrst_in;
  logic              psel_in;
  logic              penable_in;
  logic              pwrite_in;
  logic [31:0]       paddr_in;
  logic [31:0]       pwdata_in;
  logic [31:0]       prdata_out;
  logic              pready_out;
  logic              pslverr_out;
  logic [8:0]        ext_in;
  logic              vbus_in;
  logic              dminus_in;
  logic              dplus_in;
  logic              nmi_in;
  logic [11:0]       flag_out;
  logic              nmi_out;
  logic              irq_out;
  logic [12:0]       pin_req;
  int                num_errors;
  int                check_count;
  int                cycles;

  eid_top dut (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .ext_in(ext_in),
    .vbus_in(vbus_in), .dminus_in(dminus_in), .dplus_in(dplus_in),
    .nmi_in(nmi_in), .flag_out(flag_out), .nmi_out(nmi_out),
    .irq_out(irq_out));

  eid_pins pins (.sys_clk_in(sys_clk_in), .req_in(pin_req),
    .ext_out(ext_in), .vbus_out(vbus_in), .dminus_out(dminus_in),
    .dplus_out(dplus_in), .nmi_out(nmi_in));

  initial begin
    sys_clk_in = 1'b0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 8000) begin
      num_errors++;
      stop_test();
    end
  end

  task automatic check(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic w, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic err);
    int n;
    @(posedge sys_clk_in);
    psel_in    <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in  <= w;
    paddr_in   <= a;
    pwdata_in  <= d;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    r = prdata_out;
    err = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        err;
    apb(1'b1, a, d, r, err);
  endtask

  task automatic rd(input string nm, input logic [31:0] a,
                    input logic [31:0] exp);
    logic [31:0] r;
    logic        err;
    apb(1'b0, a, 32'h0, r, err);
    check(nm, exp, r);
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk_in);
  endtask

  task automatic chk_flags(input logic [11:0] exp);
    check("flag_out", {20'h0, exp}, {20'h0, flag_out});
  endtask

  initial begin
    logic [31:0] r;
    logic        err;
    int          e;
    int          b;
    int          sh;
    num_errors = 0;
    check_count = 0;
    cycles = 0;
    nrst_in = 1'b0;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = 32'h0;
    pwdata_in = 32'h0;
    pin_req = 13'h0;
    tick(3);
    nrst_in <= 1'b1;
    rd("cfg2", EID_OFF_CFG2, 32'h0);
    rd("clear", EID_OFF_CLR, 32'h0);
    rd("nmi_clear", EID_OFF_NMI_CLR, 32'h0);
    apb(1'b0, 32'h40002460, 32'h0, r, err);
    check("unmapped_err", 32'h1, {31'h0, err});
    check("unmapped_rd", 32'h0, r);
    // Each CFG2 detector (VBUS, D-, D+, input 8) through all eight trigger codes, pin starting low.
    for (int d = 0; d < 4; d++) begin
      b = 11 - d;
      sh = 12 - 4 * d;
      for (int c = 0; c < 8; c++) begin
        e = (c > 4) ? c - 4 : c;
        wr(EID_OFF_CFG2, {28'h0, 1'b1, 3'(c)} << sh);
        rd("cfg2", EID_OFF_CFG2, {28'h0, 1'b1, 3'(c)} << sh);
        tick(6);
        wr(EID_OFF_CLR, 32'h1 << b);
        tick(4);
        chk_flags(12'(e == 4) << b);
        pin_req[b] <= 1'b1;
        tick(6);
        chk_flags(12'(e != 1) << b);
        if (b > 8) begin
          rd("wake", EID_OFF_WAKE, 32'(e != 1) << (b - 9));
        end
        wr(EID_OFF_CLR, 32'h1 << b);
        tick(4);
        chk_flags(12'(e == 3) << b);
        pin_req[b] <= 1'b0;
        tick(6);
        chk_flags(12'(e != 0) << b);
        wr(EID_OFF_CLR, 32'h1 << b);
        tick(4);
        chk_flags(12'(e == 4) << b);
      end
      wr(EID_OFF_CFG2, 32'h3 << sh);
      pin_req[b] <= 1'b1;
      tick(6);
      wr(EID_OFF_CLR, 32'h1 << b);
      tick(4);
      chk_flags(12'h0);
      pin_req[b] <= 1'b0;
      tick(6);
    end
    wr(EID_OFF_CLR, 32'h0fff);
    wr(EID_OFF_STAT, 32'h1fff);
    wr(EID_OFF_CFG0, 32'h8888);
    wr(EID_OFF_CFG1, 32'h8888);
    wr(EID_OFF_CFG2, 32'h0008);
    pin_req[8:0] <= 9'h1ff;
    tick(6);
    chk_flags(12'h1ff);
    wr(EID_OFF_CLR, 32'h0155);
    tick(4);
    chk_flags(12'h0aa);
    rd("clear", EID_OFF_CLR, 32'h0);
    wr(EID_OFF_CLR, 32'h00aa);
    tick(4);
    chk_flags(12'h0);
    rd("status", EID_OFF_STAT, 32'h01ff);
    check("irq_masked", 32'h0, {31'h0, irq_out});
    wr(EID_OFF_MASK, 32'h0001);
    tick(2);
    check("irq_on", 32'h1, {31'h0, irq_out});
    wr(EID_OFF_STAT, 32'h0001);
    tick(2);
    check("irq_off", 32'h0, {31'h0, irq_out});
    rd("status", EID_OFF_STAT, 32'h01fe);
    wr(EID_OFF_MASK, 32'h0002);
    tick(2);
    check("irq_on", 32'h1, {31'h0, irq_out});
    pin_req[12] <= 1'b1;
    tick(6);
    check("nmi_out", 32'h1, {31'h0, nmi_out});
    wr(EID_OFF_NMI_CLR, 32'h0);
    tick(4);
    check("nmi_out", 32'h1, {31'h0, nmi_out});
    wr(EID_OFF_NMI_CLR, 32'h1);
    tick(4);
    check("nmi_out", 32'h0, {31'h0, nmi_out});
    rd("nmi_clear", EID_OFF_NMI_CLR, 32'h0);
    stop_test();
  end
endmodule // eid_top_tb
`default_nettype wire
